// *** rtl/pit_pkg.sv ***
/*
  Constants shared by the PWM / interval timer block: register map,
  field positions, reset values and count-source figures.
  Assumes an APB master with 32-bit data and a 10 MHz pclk.
*/
`default_nettype none

package pit_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_START = 8'h00;
  localparam logic [7:0] REG_TA_MODE = 8'h04;
  localparam logic [7:0] REG_TA_VALUE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_TB_BASE = 8'h20;
  localparam int TB_STRIDE = 8;
  localparam int TB_VALUE_OFS = 4;

  // ****************************************
  // Mode register fields
  // ****************************************
  localparam int F_MODE_LSB = 0;
  localparam int F_TA_8BIT = 2;
  localparam int F_TA_TRIG_EN = 3;
  localparam int F_TA_TRIG_OVF = 4;
  localparam int F_TA_EDGE_RISE = 5;
  localparam int F_SRC_LSB = 6;
  localparam int MODE_W = 8;

  typedef enum logic [1:0] {PIT_TB_TIMER, PIT_TB_EVENT, PIT_TB_MEASURE, PIT_TB_RSVD} pit_tbmode_e;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] CYC16 = 16'hffff;
  localparam logic [15:0] CYC8 = 16'h00ff;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [31:0] TA_READ_VALUE = 32'h0000_0000;

endpackage

`default_nettype wire

// *** rtl/pit_pwm.sv ***
/*
  Timer A in pulse width modulation mode: one channel with pulse output.
  Assumes tick is a one-cycle pulse of the selected count source.
*/
`default_nettype none

module pit_pwm
  import pit_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic tick, // Count-source pulse
  input wire logic start, // Count start flag
  input wire logic mode8, // 8-bit modulator
  input wire logic wait_trig, // Start waits for trigger
  input wire logic trig, // Trigger event pulse
  input wire logic wr, // Value write strobe
  input wire logic [15:0] wdata, // Value written
  output logic pulse, // PWM output
  output logic fall // Pulse fell, one cycle
);

  typedef enum {PIT_IDLE, PIT_ARMED, PIT_RUN} pit_pwm_e;
  pit_pwm_e state_ff, nxt_state;
  logic [15:0] rld_ff, hi_ff, ph_ff;
  logic [7:0] pre_ff, m_ff;
  logic pulse_ff, pulse_d_ff, fall_ff, itick, go;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      PIT_IDLE: if (start) nxt_state = wait_trig ? PIT_ARMED : PIT_RUN;
      PIT_ARMED: if (!start) nxt_state = PIT_IDLE; else if (trig) nxt_state = PIT_RUN;
      PIT_RUN: if (!start) nxt_state = PIT_IDLE;
      default: nxt_state = PIT_IDLE;
    endcase
  end

  assign itick = (state_ff == PIT_RUN) && tick && (pre_ff == 8'h00);
  // New cycle on entering run or when the period counter wraps
  assign go = ((state_ff != PIT_RUN) && (nxt_state == PIT_RUN))
           || (itick && (ph_ff == 16'h0000) && start);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) state_ff <= PIT_IDLE;
    else state_ff <= nxt_state;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) rld_ff <= VALUE_RST;
    else if (wr) rld_ff <= wdata;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_ff <= VALUE_RST;
      ph_ff <= VALUE_RST;
      pre_ff <= 8'h00;
      m_ff <= 8'h00;
      pulse_ff <= 1'b0;
    end
    else if (go)
    begin
      hi_ff <= mode8 ? {8'h00, rld_ff[15:8]} : rld_ff;
      m_ff <= mode8 ? rld_ff[7:0] : 8'h00;
      pre_ff <= mode8 ? rld_ff[7:0] : 8'h00;
      ph_ff <= (mode8 ? CYC8 : CYC16) - 16'h0001;
      pulse_ff <= mode8 ? (rld_ff[15:8] != 8'h00) : (rld_ff != 16'h0000);
    end
    else if (nxt_state != PIT_RUN)
    begin
      pulse_ff <= 1'b0;
      if (wr && state_ff == PIT_IDLE) hi_ff <= wdata;
    end
    else if (tick)
    begin
      if (pre_ff == 8'h00)
      begin
        pre_ff <= m_ff;
        ph_ff <= ph_ff - 16'h0001;
        if (hi_ff != 16'h0000) hi_ff <= hi_ff - 16'h0001;
        pulse_ff <= (hi_ff > 16'h0001);
      end
      else pre_ff <= pre_ff - 8'h01;
    end
  end

  // Delayed copy finds the fall; request trails the pin by one cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) pulse_d_ff <= 1'b0;
    else pulse_d_ff <= pulse_ff;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) fall_ff <= 1'b0;
    else fall_ff <= pulse_d_ff && !pulse_ff;

  assign pulse = pulse_ff;
  assign fall = fall_ff;

endmodule

`default_nettype wire

// *** rtl/pit_tmrb.sv ***
/*
  One timer B channel; only timer (interval) mode counts here.
  Assumes tick is a one-cycle pulse of the selected count source.
*/
`default_nettype none

module pit_tmrb
  import pit_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic tick, // Count-source pulse
  input wire logic start, // Count start flag
  input wire logic [1:0] mode, // Mode field
  input wire logic wr, // Value write strobe
  input wire logic [15:0] wdata, // Value written
  output logic [15:0] count, // Live count
  output logic uflow // Underflow, one cycle
);

  logic [15:0] rld_ff, cnt_ff;
  logic uf_ff, run;

  // Event and measurement modes are not served: counter holds
  assign run = start && (pit_tbmode_e'(mode) == PIT_TB_TIMER);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) rld_ff <= VALUE_RST;
    else if (wr) rld_ff <= wdata;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt_ff <= VALUE_RST;
    else if (wr && !run) cnt_ff <= wdata;
    else if (run && tick) cnt_ff <= (cnt_ff == 16'h0000) ? rld_ff : cnt_ff - 16'h0001;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) uf_ff <= 1'b0;
    else uf_ff <= run && tick && (cnt_ff == 16'h0000);

  assign count = cnt_ff;
  assign uflow = uf_ff;

endmodule

`default_nettype wire

// *** rtl/pit_top.sv ***
/*
  PWM timer A channel and a group of interval timer B channels behind APB.
  Assumes pins and the subclock tick are synchronous to pclk.
*/
`default_nettype none

module pit_top
  import pit_pkg::*;
#(
  parameter int NB = 6 // Timer B channels
)
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic subclock_div32_source, // Subclock/32 tick pulse
  input wire logic timer_a_trigger_pin, // Trigger input
  output logic timer_a_pulse_pin, // PWM output
  output logic ta_irq_req, // Timer A request pulse
  output logic [NB-1:0] tb_irq_req // Timer B request pulses
);

  import pit_pkg::*;

  generate
    if (NB < 1 || NB > 8)
    begin : g_nb_check
      $error("NB out of range");
    end
  endgenerate

  // ****************************************
  // Count sources
  // ****************************************
  logic [4:0] div_ff;
  logic [3:0] tick_ff;
  logic mainclock_undivided_source, mainclock_div8_source, mainclock_div32_source;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) div_ff <= 5'h00;
    else div_ff <= div_ff + 5'h01;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) tick_ff <= 4'h0;
    else tick_ff <= {subclock_div32_source,
                     div_ff == DIV32_LAST,
                     div_ff[2:0] == DIV8_LAST[2:0],
                     1'b1};

  assign mainclock_undivided_source = tick_ff[0];
  assign mainclock_div8_source = tick_ff[1];
  assign mainclock_div32_source = tick_ff[2];

  logic [3:0] srcs;
  assign srcs = {tick_ff[3], mainclock_div32_source, mainclock_div8_source,
                 mainclock_undivided_source};

  // Ticks come in as an argument: a connection only wakes on its arguments
  function automatic logic pick_src(input logic [MODE_W-1:0] mr, input logic [3:0] src);
    pick_src = src[mr[F_SRC_LSB +: 2]];
  endfunction

  // ****************************************
  // Software registers
  // ****************************************
  logic [NB:0] start_ff;
  logic [NB:0] stat_ff;
  logic [MODE_W-1:0] ta_mode_ff;
  logic [MODE_W-1:0] tb_mode_ff [NB];
  logic [15:0] tb_count [NB];
  logic [NB-1:0] tb_uf;
  logic ta_fall, ta_pulse;
  logic wr_en, rd_setup;

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;

  function automatic logic is_tb(input logic [7:0] a);
    is_tb = (a >= REG_TB_BASE) && ({24'h0, a} < {24'h0, REG_TB_BASE} + 32'(TB_STRIDE * NB))
         && (a[1:0] == 2'b00);
  endfunction

  function automatic int tb_ch(input logic [7:0] a);
    tb_ch = int'(a - REG_TB_BASE) / TB_STRIDE;
  endfunction

  function automatic logic tb_is_val(input logic [7:0] a);
    tb_is_val = (int'(a - REG_TB_BASE) % TB_STRIDE) == TB_VALUE_OFS;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) start_ff <= '0;
    else if (wr_en && paddr == REG_START) start_ff <= pwdata[NB:0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ta_mode_ff <= MODE_RST;
    else if (wr_en && paddr == REG_TA_MODE) ta_mode_ff <= pwdata[MODE_W-1:0];

  // Sticky event flags; a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) stat_ff <= '0;
    else stat_ff <= ((wr_en && paddr == REG_STATUS) ? stat_ff & ~pwdata[NB:0] : stat_ff)
                    | {tb_uf, ta_fall};

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++)
    begin : g_tb
      logic wr_val;
      assign wr_val = wr_en && is_tb(paddr) && tb_ch(paddr) == gi && tb_is_val(paddr);

      always_ff @(posedge pclk or negedge presetn)
        if (!presetn) tb_mode_ff[gi] <= MODE_RST;
        else if (wr_en && is_tb(paddr) && tb_ch(paddr) == gi && !tb_is_val(paddr))
          tb_mode_ff[gi] <= pwdata[MODE_W-1:0];

      // No channel drives a pin; any input pins remain plain ports
      pit_tmrb u_tmrb (
        .pclk(pclk),
        .presetn(presetn),
        .tick(pick_src(tb_mode_ff[gi], srcs)),
        .start(start_ff[gi+1]),
        .mode(tb_mode_ff[gi][F_MODE_LSB +: 2]),
        .wr(wr_val),
        .wdata(pwdata[15:0]),
        .count(tb_count[gi]),
        .uflow(tb_uf[gi])
      );
    end
  endgenerate

  // ****************************************
  // Timer A trigger and PWM
  // ****************************************
  logic trig_pin_ff, trig_evt;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) trig_pin_ff <= 1'b0;
    else trig_pin_ff <= timer_a_trigger_pin;

  // Trigger pin is only looked at when trigger start is chosen
  always_comb
  begin
    if (ta_mode_ff[F_TA_TRIG_OVF]) trig_evt = tb_uf[0];
    else if (ta_mode_ff[F_TA_EDGE_RISE]) trig_evt = timer_a_trigger_pin && !trig_pin_ff;
    else trig_evt = !timer_a_trigger_pin && trig_pin_ff;
  end

  pit_pwm u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .tick(pick_src(ta_mode_ff, srcs)),
    .start(start_ff[0]),
    .mode8(ta_mode_ff[F_TA_8BIT]),
    .wait_trig(ta_mode_ff[F_TA_TRIG_EN]),
    .trig(trig_evt),
    .wr(wr_en && paddr == REG_TA_VALUE),
    .wdata(pwdata[15:0]),
    .pulse(ta_pulse),
    .fall(ta_fall)
  );

  assign timer_a_pulse_pin = ta_pulse;
  assign ta_irq_req = ta_fall;
  assign tb_irq_req = tb_uf;

  // ****************************************
  // APB response
  // ****************************************
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, pslverr_ff, mapped;

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == REG_START) nxt_prdata = 32'(start_ff);
    else if (paddr == REG_TA_MODE) nxt_prdata = 32'(ta_mode_ff);
    else if (paddr == REG_TA_VALUE) nxt_prdata = TA_READ_VALUE;
    else if (paddr == REG_STATUS) nxt_prdata = 32'(stat_ff);
    else if (is_tb(paddr))
    begin
      if (tb_is_val(paddr)) nxt_prdata = {16'h0000, tb_count[tb_ch(paddr)]};
      else nxt_prdata = {24'h0, tb_mode_ff[tb_ch(paddr)]};
    end
    else mapped = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) pready_ff <= 1'b0;
    else pready_ff <= rd_setup;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) pslverr_ff <= 1'b0;
    else pslverr_ff <= rd_setup && !mapped;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) prdata_ff <= 32'h0000_0000;
    else if (rd_setup) prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

endmodule

`default_nettype wire

// *** tb/pit_pins.sv ***
/* Far side of the timer A pins: trigger source and pulse meter.
   Assumes pulse is synchronous to pclk; trigger idles high. */
`default_nettype none
module pit_pins
(
  input wire logic pclk, // Clock
  input wire logic pulse, // Pulse pin from block
  output var logic trig, // Trigger pin to block
  output var logic [31:0] hi, // Last high width
  output var logic [31:0] per // Last rise to rise
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cnt = '0;
  logic [31:0] t_rise = '0;
  logic prev = 1'b0;
  initial trig = 1'b1;
  initial hi = '0;
  initial per = '0;
  always @(posedge pclk)
  begin
    cnt <= cnt + 1;
    prev <= pulse;
    if (pulse && !prev)
    begin
      per <= cnt - t_rise;
      t_rise <= cnt;
    end
    if (!pulse && prev)
      hi <= cnt - t_rise;
  end
  // One-cycle low pulse: falling edge then back idle
  task automatic fire;
    @(posedge pclk);
    trig <= 1'b0;
    @(posedge pclk);
    trig <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** tb/pit_top_asserts.sv ***
/* Port checker for pit_top: APB answer, pulse pin and request pulses.
   Bound to every pit_top; NB follows the bound instance. */
`default_nettype none
module pit_top_chk
  import pit_pkg::*;
#(
  parameter int NB = 6 // Timer B channels
)
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic timer_a_pulse_pin, // PWM output
  input wire logic ta_irq_req, // Timer A request
  input wire logic [NB-1:0] tb_irq_req // Timer B requests
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  logic wr_start;
  assign mapped = paddr[1:0] == 2'h0 && (paddr <= REG_STATUS ||
    (paddr >= REG_TB_BASE && 32'(paddr) < 32'(REG_TB_BASE) + TB_STRIDE * NB));
  assign wr_start = psel && penable && pready && pwrite && paddr == REG_START;
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; pready |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_ta_read; pready && !pwrite && paddr == REG_TA_VALUE |-> prdata == TA_READ_VALUE;
  endproperty
  a_ta_read: assert property (p_ta_read) else $error("timer A read not fixed");
  property p_fall_irq; $fell(timer_a_pulse_pin) |=> ta_irq_req; endproperty
  a_fall_irq: assert property (p_fall_irq) else $error("no request after fall");
  property p_irq_cause; ta_irq_req |-> $past(timer_a_pulse_pin, 2) && !$past(timer_a_pulse_pin);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without fall");
  property p_stop; wr_start && !pwdata[0] |-> ##2 !timer_a_pulse_pin [*3]; endproperty
  a_stop: assert property (p_stop) else $error("pulse runs after stop");
  property p_tb_stop; wr_start && pwdata[NB:1] == '0 |-> ##3 (tb_irq_req == '0) [*2];
  endproperty
  a_tb_stop: assert property (p_tb_stop) else $error("timer B runs after stop");
endmodule
bind pit_top pit_top_chk #(.NB(NB)) u_pit_top_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_a_pulse_pin(timer_a_pulse_pin), .ta_irq_req(ta_irq_req), .tb_irq_req(tb_irq_req));
`default_nettype wire

// *** tb/pit_top_test.sv ***
/* Self-checking bench for pit_top: APB master, pin partner, timers.
   Assumes the port checker is bound to pit_top. */
`default_nettype none
module pit_top_test;
  import pit_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NB = 6;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trig, pulse, ta_irq, err;
  logic sub_tick = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, hi, per, rd;
  logic [NB-1:0] tb_irq;
  int n_fail = 0;
  int checks = 0;
  int seed = 46;
  int sub_cnt = 0;
  pit_top #(.NB(NB)) u_pit_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .subclock_div32_source(sub_tick),
    .timer_a_trigger_pin(trig), .timer_a_pulse_pin(pulse), .ta_irq_req(ta_irq),
    .tb_irq_req(tb_irq));
  pit_pins u_pit_pins (.pclk(pclk), .pulse(pulse), .trig(trig), .hi(hi), .per(per));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Subclock tick every 5 cycles keeps the slowest source short
  always @(posedge pclk)
  begin
    sub_cnt <= (sub_cnt + 1) % 5;
    sub_tick <= sub_cnt == 0;
  end
  function automatic int tb_per(input int n, input int s);
    return (n + 1) * (s == 0 ? 1 : s == 1 ? 8 : s == 2 ? 32 : 5);
  endfunction
  function automatic int pwm_hi(input logic b8, input int n, input int m);
    return b8 ? n * (m + 1) : n;
  endfunction
  function automatic int pwm_per(input logic b8, input int m);
    return b8 ? 255 * (m + 1) : 65535;
  endfunction
  function automatic logic [7:0] tba(input int i, input int ofs);
    return 8'(32'(REG_TB_BASE) + TB_STRIDE * i + ofs);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_sig(input int idx, input int lim, output int k);
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while ((idx < 0 ? ta_irq : tb_irq[idx]) !== 1'b1 && k < lim);
    if (k >= lim)
      chk(32'h0, 32'h1);
  endtask
  task automatic conclude;
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (95000) @(posedge pclk);
    n_fail++;
    conclude();
  end
  initial
  begin
    int n, m, c, i;
    logic b8;
    logic [31:0] x;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (tb_irq[j])
      rdchk(tba(j, TB_VALUE_OFS), 32'(VALUE_RST));
    rdchk(REG_TA_MODE, 32'(MODE_RST));
    rdchk(REG_START, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, tba(NB, 0), 32'h0);
    chk(32'(err), 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      i = $unsigned($random(seed)) % NB;
      // From 5 up no reload lands between the write and the live read at f1
      n = 5 + $unsigned($random(seed)) % 6;
      wr(tba(i, 0), 32'(s << F_SRC_LSB));
      wr(tba(i, TB_VALUE_OFS), 32'(n));
      rdchk(tba(i, TB_VALUE_OFS), 32'(n));
      wr(REG_START, 32'(1 << (i + 1)));
      wait_sig(i, 3000, c);
      wait_sig(i, 3000, c);
      chk(32'(c), 32'(tb_per(n, s)));
      wr(tba(i, TB_VALUE_OFS), 32'(n + 9));
      apb(1'b0, tba(i, TB_VALUE_OFS), 32'h0);
      chk(32'(rd <= n), 32'h1);
      wait_sig(i, 3000, c);
      wait_sig(i, 3000, c);
      chk(32'(c), 32'(tb_per(n + 9, s)));
      wr(tba(i, 0), 32'(1 | (s << F_SRC_LSB)));
      apb(1'b0, tba(i, TB_VALUE_OFS), 32'h0);
      x = rd;
      repeat (70) @(posedge pclk);
      rdchk(tba(i, TB_VALUE_OFS), x);
      wr(REG_START, 32'h0);
    end
    for (int t = 0; t < 4; t++)
    begin
      b8 = t != 2;
      n = b8 ? 1 + $unsigned($random(seed)) % 200 : 50 + $unsigned($random(seed)) % 500;
      m = $unsigned($random(seed)) % 3;
      wr(REG_TA_MODE, 32'((b8 << F_TA_8BIT) | ((t == 1 || t == 3) << F_TA_TRIG_EN)
        | ((t == 3) << F_TA_TRIG_OVF) | ((t == 1) << F_TA_EDGE_RISE)));
      wr(REG_TA_VALUE, 32'(b8 ? (n << 8) | m : n));
      if (t == 3)
      begin
        wr(tba(0, 0), 32'h0);
        wr(tba(0, TB_VALUE_OFS), 32'h14);
      end
      wr(REG_START, t == 3 ? 32'h3 : 32'h1);
      if (t == 1)
      begin
        repeat (30) @(posedge pclk);
        chk(32'(pulse), 32'h0);
        u_pit_pins.fire();
        // Rising edge chosen: the fall alone must not start the run
        @(posedge pclk);
        chk(32'(pulse), 32'h0);
        @(posedge pclk);
        chk(32'(pulse), 32'h1);
      end
      else if (t == 3)
      begin
        repeat (5) @(posedge pclk);
        chk(32'(pulse), 32'h0);
      end
      wait_sig(-1, 70000, c);
      u_pit_pins.fire();
      wait_sig(-1, 70000, c);
      chk(hi, 32'(pwm_hi(b8, n, m)));
      chk(per, 32'(pwm_per(b8, m)));
      if (b8)
      begin
        n = 1 + $unsigned($random(seed)) % 250;
        wr(REG_TA_VALUE, 32'((n << 8) | m));
        wait_sig(-1, 2000, c);
        wait_sig(-1, 2000, c);
        chk(hi, 32'(pwm_hi(b8, n, m)));
      end
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(rd[0]), 32'h1);
      wr(REG_START, 32'h0);
      repeat (5) @(posedge pclk);
      chk(32'(pulse), 32'h0);
      wr(REG_STATUS, 32'hff);
      rdchk(REG_STATUS, 32'h0);
    end
    conclude();
  end
endmodule
`default_nettype wire
